// >>> src/fmbr_pkg.sv
// Constants and types shared by the flash map and boot remap block
package fmbr_pkg;
    localparam int          PAGE_BYTES_I   = 2048;
    localparam int          PAGE_HW        = PAGE_BYTES_I / 2;
    localparam int          PAGES_SMALL    = 64;
    localparam int          PAGES_LARGE    = 96;
    localparam int          ARR_PAGES      = PAGES_LARGE + 2;
    localparam int          ARR_WORDS      = ARR_PAGES * PAGE_HW;
    localparam int          IDX_W          = 17;
    localparam int          OFS_W          = 10;
    localparam int          PG_W           = IDX_W - OFS_W;
    localparam logic [31:0] PAGE_BYTES     = 32'h0000_0800;
    localparam logic [31:0] MAIN_BYTES_SM  = 32'h0002_0000;
    localparam logic [31:0] MAIN_BYTES_LG  = 32'h0003_0000;
    localparam logic [31:0] ALIAS_BASE     = 32'h0000_0000;
    localparam logic [31:0] MAIN_BASE      = 32'h0800_0000;
    localparam logic [31:0] FACT_BASE      = 32'h0804_0000;
    localparam logic [31:0] USER_BASE      = 32'h0804_0800;
    localparam logic [6:0]  FACT_PAGE      = 7'h60;
    localparam logic [6:0]  USER_PAGE      = 7'h61;
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
    localparam logic [15:0] ERASED_HW      = {2{ERASED_BYTE}};
    localparam logic [1:0]  CMD_READ       = 2'h0;
    localparam logic [1:0]  CMD_PROG       = 2'h1;
    localparam logic [1:0]  CMD_ERASE      = 2'h2;
    localparam logic [1:0]  SIZE_BYTE      = 2'h0;
    localparam logic [1:0]  SIZE_HALF      = 2'h1;
    localparam logic [1:0]  SIZE_WORD      = 2'h2;
    localparam logic [1:0]  CAP_CYCLES     = 2'h3;

    typedef enum logic [1:0] {
        REG_NONE = 2'h0,
        REG_MAIN = 2'h1,
        REG_FACT = 2'h2,
        REG_USER = 2'h3
    } fmbr_region_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_PROG  = 2'b11,
        ST_ERASE = 2'b10
    } fmbr_state_e;
endpackage : fmbr_pkg

// >>> src/fmbr_array.sv
// Half-word storage for the main, factory and user flash pages
`timescale 1ns/10ps
module fmbr_array
    import fmbr_pkg::*;
(
    input  wire logic                       mclk,
    input  wire logic [fmbr_pkg::IDX_W-1:0] raddr,
    output logic      [15:0]                rdata,
    input  wire logic                       we,
    input  wire logic [fmbr_pkg::IDX_W-1:0] waddr,
    input  wire logic [15:0]                wdata
);
    logic [15:0] mem [ARR_WORDS];

    // Synchronous read, one cycle latency
    always_ff @(posedge mclk) begin
        rdata <= mem[raddr];
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
endmodule : fmbr_array

// >>> src/fmbr_top.sv
// Flash address decode, boot remap and program/erase sequencing
//
// Overview of operation
// (RQ1) Main array is 2048-byte pages: 64 pages small part, 96 pages large part.
// (RQ2) Factory and user info regions are each one separate 2048-byte page.
// (RQ3) Erase always clears exactly one whole page, never less.
// (RQ4) Program writes one aligned 16-bit half-word; narrow or misaligned writes refused.
// (RQ5) Normal boot: main array visible at zero and at 0x08000000.
// (RQ6) Serial bootload: main array only at 0x08000000, no alias at zero.
// (RQ7) Factory page always starts at 0x08040000.
// (RQ8) Serial bootload: factory page also aliased at address zero.
// (RQ9) Factory page programmable only in manufacturing mode, refused in field.
// (RQ10) Debug host programs flash through a helper routine running in RAM.
// (RQ11) Main array code should be linked to run at 0x08000000.
// (RQ12) User info page starts at 0x08040800, right after factory page.
// (RQ13) Erased flash byte reads back as 0xFF.
// (RQ14) Boot mode captured at reset and held until next reset.
// (RQ15) Program only clears bits; setting bits needs a page erase.
`timescale 1ns/10ps
module fmbr_top
    import fmbr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        boot_serial_pin,
    input  wire logic        large_variant_pin,
    input  wire logic        manufacturing_pin,
    input  wire logic        req_valid,
    input  wire logic [1:0]  req_cmd,
    input  wire logic [1:0]  req_size,
    input  wire logic [31:0] req_addr,
    input  wire logic [15:0] req_wdata,
    output logic             busy,
    output logic             rsp_valid,
    output logic             rsp_err,
    output logic      [15:0] rsp_rdata,
    output logic             boot_serial
);
    import fmbr_pkg::*;

    typedef struct packed {
        fmbr_state_e      state;
        logic [1:0]       cap_cnt;
        logic             boot_s1;
        logic             boot_s2;
        logic             large_s1;
        logic             large_s2;
        logic             mfg_s1;
        logic             mfg_s2;
        logic             boot_serial;
        logic             large_part;
        logic [IDX_W-1:0] idx;
        logic [15:0]      wdata;
        logic             busy;
        logic             rsp_valid;
        logic             rsp_err;
        logic [15:0]      rdata;
    } fmbr_regs_s;

    fmbr_regs_s       st_reg;
    fmbr_regs_s       st_next;
    logic [IDX_W-1:0] arr_raddr;
    logic [15:0]      arr_rdata;
    logic             arr_we;
    logic [IDX_W-1:0] arr_waddr;
    logic [15:0]      arr_wdata;
    fmbr_region_e     req_region;
    logic             taken;
    logic             refuse;

    // Which flash region an address falls in under the captured boot mode
    function automatic fmbr_region_e region_of(input logic [31:0] a, input logic serial, input logic large_part);
        logic [31:0] main_bytes;
        main_bytes = large_part ? MAIN_BYTES_LG : MAIN_BYTES_SM;                         // see RQ1
        if (a >= MAIN_BASE && a < MAIN_BASE + main_bytes) begin
            region_of = REG_MAIN;                                                        // see RQ11
        end else if (a >= FACT_BASE && a < FACT_BASE + PAGE_BYTES) begin
            region_of = REG_FACT;                                                        // see RQ7
        end else if (a >= USER_BASE && a < USER_BASE + PAGE_BYTES) begin
            region_of = REG_USER;                                                        // see RQ12
        end else if (!serial && a >= ALIAS_BASE && a < ALIAS_BASE + main_bytes) begin
            region_of = REG_MAIN;                                                        // see RQ5
        end else if (serial && a >= ALIAS_BASE && a < ALIAS_BASE + PAGE_BYTES) begin
            region_of = REG_FACT;                                                        // see RQ6 see RQ8
        end else begin
            region_of = REG_NONE;
        end
    endfunction : region_of

    // Half-word index into the storage array; info pages sit above the main array
    function automatic logic [IDX_W-1:0] index_of(input logic [31:0] a, input fmbr_region_e rg);
        logic [31:0] ofs;
        ofs = (a >= MAIN_BASE) ? a - MAIN_BASE : a - ALIAS_BASE;
        unique case (rg)
            REG_FACT: index_of = {FACT_PAGE, a[OFS_W:1]};                                // see RQ2
            REG_USER: index_of = {USER_PAGE, a[OFS_W:1]};                                // see RQ2
            REG_MAIN: index_of = ofs[IDX_W:1];
            REG_NONE: index_of = '0;
        endcase
    endfunction : index_of

    assign req_region = region_of(req_addr, st_reg.boot_serial, st_reg.large_part);
    assign taken      = st_reg.state == ST_IDLE && st_reg.cap_cnt == CAP_CYCLES && req_valid;
    assign refuse     = req_region == REG_NONE
                     || !(req_cmd == CMD_READ || req_cmd == CMD_PROG || req_cmd == CMD_ERASE)
                     || (req_cmd == CMD_PROG && (req_size != SIZE_HALF || req_addr[0]))          // see RQ4
                     || (req_cmd != CMD_READ && req_region == REG_FACT && !st_reg.mfg_s2);       // see RQ9

    always_comb begin
        st_next           = st_reg;
        st_next.rsp_valid = 1'b0;
        st_next.rsp_err   = 1'b0;
        st_next.boot_s1   = boot_serial_pin;
        st_next.boot_s2   = st_reg.boot_s1;
        st_next.large_s1  = large_variant_pin;
        st_next.large_s2  = st_reg.large_s1;
        st_next.mfg_s1    = manufacturing_pin;
        st_next.mfg_s2    = st_reg.mfg_s1;
        arr_raddr         = st_reg.idx;
        arr_we            = 1'b0;
        arr_waddr         = st_reg.idx;
        arr_wdata         = ERASED_HW;
        unique case (st_reg.state)
            ST_IDLE: begin
                if (st_reg.cap_cnt != CAP_CYCLES) begin
                    st_next.cap_cnt = st_reg.cap_cnt + 2'h1;
                    if (st_reg.cap_cnt == CAP_CYCLES - 2'h1) begin
                        st_next.boot_serial = st_reg.boot_s2;                            // see RQ14
                        st_next.large_part  = st_reg.large_s2;
                    end
                end else if (req_valid) begin
                    arr_raddr     = index_of(req_addr, req_region);
                    st_next.idx   = arr_raddr;
                    st_next.wdata = req_wdata;
                    if (refuse) begin
                        st_next.rsp_valid = 1'b1;
                        st_next.rsp_err   = 1'b1;
                    end else if (req_cmd == CMD_READ) begin
                        st_next.state = ST_READ;
                    end else if (req_cmd == CMD_PROG) begin
                        st_next.state = ST_PROG;
                    end else begin
                        st_next.idx   = {arr_raddr[IDX_W-1:OFS_W], {OFS_W{1'b0}}};       // see RQ3
                        st_next.state = ST_ERASE;
                    end
                end
            end
            ST_READ: begin
                st_next.rdata     = arr_rdata;
                st_next.rsp_valid = 1'b1;
                st_next.state     = ST_IDLE;
            end
            ST_PROG: begin
                arr_we            = 1'b1;
                arr_wdata         = arr_rdata & st_reg.wdata;                            // see RQ15
                st_next.rsp_valid = 1'b1;
                st_next.state     = ST_IDLE;
            end
            ST_ERASE: begin
                arr_we      = 1'b1;
                arr_wdata   = ERASED_HW;                                                 // see RQ13
                st_next.idx = st_reg.idx + 1'b1;
                if (&st_reg.idx[OFS_W-1:0]) begin                                        // see RQ3
                    st_next.rsp_valid = 1'b1;
                    st_next.state     = ST_IDLE;
                end
            end
        endcase
        st_next.busy = st_next.state != ST_IDLE || st_next.cap_cnt != CAP_CYCLES;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg      <= '0;
            st_reg.busy <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    fmbr_array u_array (
        .mclk  (mclk),
        .raddr (arr_raddr),
        .rdata (arr_rdata),
        .we    (arr_we),
        .waddr (arr_waddr),
        .wdata (arr_wdata)
    );

    assign busy        = st_reg.busy;
    assign rsp_valid   = st_reg.rsp_valid;
    assign rsp_err     = st_reg.rsp_err;
    assign rsp_rdata   = st_reg.rdata;
    assign boot_serial = st_reg.boot_serial;

    // Cycles spent in one erase, read only by the checks below
    logic [IDX_W-1:0] erase_cycles;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            erase_cycles <= '0;
        end else if (st_reg.state == ST_ERASE) begin
            erase_cycles <= erase_cycles + 1'b1;
        end else begin
            erase_cycles <= '0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_erase_start;
        taken && req_cmd == CMD_ERASE && !refuse;
    endsequence
    sequence s_erase_entry;
        st_reg.state == ST_ERASE && st_reg.idx[OFS_W-1:0] == '0;
    endsequence

    a_erase_whole_page: assert property (s_erase_start |=> s_erase_entry)               // see RQ3
        else $error("erase did not start at page base");
    a_erase_length: assert property (st_reg.state == ST_ERASE && st_next.state == ST_IDLE  // see RQ3
                                     |-> erase_cycles == PAGE_HW - 1)
        else $error("erase did not cover exactly one page");
    a_erase_fills_ones: assert property (st_reg.state == ST_ERASE |-> arr_we && arr_wdata == ERASED_HW) // see RQ13
        else $error("erase wrote a value other than all ones");
    a_prog_clears_only: assert property (st_reg.state == ST_PROG |-> (arr_wdata & ~arr_rdata) == 16'h0000) // see RQ15
        else $error("program set a bit");
    a_prog_narrow_refused: assert property (taken && req_cmd == CMD_PROG  // see RQ4
                                            && (req_size != SIZE_HALF || req_addr[0])
                                            |=> rsp_valid && rsp_err && !busy)
        else $error("narrow or misaligned program accepted");
    a_fact_prog_guard: assert property (taken && req_cmd == CMD_PROG && req_region == REG_FACT  // see RQ9
                                        && !st_reg.mfg_s2 |=> rsp_valid && rsp_err && st_reg.state == ST_IDLE)
        else $error("factory page program accepted in field");
    a_normal_alias: assert property (taken && req_cmd == CMD_READ && !st_reg.boot_serial  // see RQ5
                                     && req_addr < PAGE_BYTES |-> ##2 rsp_valid && !rsp_err)
        else $error("main array missing at address zero");
    a_serial_zero_fact: assert property (taken && st_reg.boot_serial && req_addr < PAGE_BYTES  // see RQ8
                                         |-> arr_raddr[IDX_W-1:OFS_W] == FACT_PAGE)
        else $error("factory page not aliased at zero");
    a_serial_no_main: assert property (taken && st_reg.boot_serial && req_addr >= PAGE_BYTES  // see RQ6
                                       && req_addr < MAIN_BYTES_SM |=> rsp_err)
        else $error("main array still aliased at zero");
    a_info_pages: assert property (taken && req_addr[31:12] == FACT_BASE[31:12]  // see RQ7 see RQ12
                                   |-> arr_raddr[IDX_W-1:OFS_W] == (req_addr[11] ? USER_PAGE : FACT_PAGE))
        else $error("info page placed wrongly");
    a_small_bound: assert property (taken && !st_reg.large_part  // see RQ1
                                    && req_addr == MAIN_BASE + MAIN_BYTES_SM |=> rsp_err)
        else $error("small part decoded beyond 64 pages");
    a_boot_held: assert property (st_reg.cap_cnt == CAP_CYCLES |=> $stable(boot_serial)) // see RQ14
        else $error("boot mode changed after capture");
endmodule : fmbr_top

// >>> tb/fmbr_cpu_model.sv
// Processor-side bus master model issuing read, program and erase requests
`timescale 1ns/10ps
module fmbr_cpu_model (
    input  wire logic        mclk,
    input  wire logic        busy,
    input  wire logic        rsp_valid,
    input  wire logic        rsp_err,
    input  wire logic [15:0] rsp_rdata,
    output logic             req_valid,
    output logic      [1:0]  req_cmd,
    output logic      [1:0]  req_size,
    output logic      [31:0] req_addr,
    output logic      [15:0] req_wdata
);
    initial begin
        req_valid = 1'b0;
        req_cmd   = 2'h0;
        req_size  = 2'h0;
        req_addr  = 32'h0000_0000;
        req_wdata = 16'h0000;
    end

    // One request: wait for idle, drive it for one clock, collect the one-cycle answer
    task automatic access(input logic [1:0] cmd, input logic [1:0] size, input logic [31:0] addr,
                          input logic [15:0] wdata, output logic err, output logic [15:0] rdata,
                          output logic late);
        int n;
        late  = 1'b1;
        err   = 1'b0;
        rdata = 16'h0000;
        @(posedge mclk);
        #1;
        for (n = 0; n < 64 && busy !== 1'b0; n++) begin
            @(posedge mclk);
            #1;
        end
        req_valid = 1'b1;
        req_cmd   = cmd;
        req_size  = size;
        req_addr  = addr;
        req_wdata = wdata;
        for (n = 0; n < 2048; n++) begin
            @(posedge mclk);
            #1;
            req_valid = 1'b0;
            if (rsp_valid === 1'b1) begin
                err   = rsp_err;
                rdata = rsp_rdata;
                late  = 1'b0;
                break;
            end
        end
        // Released address and data lines do not keep their last value; command and size lines do
        req_addr  = ~req_addr;
        req_wdata = ~req_wdata;
    endtask : access
endmodule : fmbr_cpu_model

// >>> tb/tb_top.sv
// Self-checking bench for the flash map, boot remap and program/erase block
`timescale 1ns/10ps
module tb_top;
    import fmbr_pkg::*;
    logic        mclk;
    logic        rst = 1'b1;
    logic        boot_serial_pin = 1'b0;
    logic        large_variant_pin = 1'b0;
    logic        manufacturing_pin = 1'b0;
    logic        req_valid;
    logic [1:0]  req_cmd;
    logic [1:0]  req_size;
    logic [31:0] req_addr;
    logic [15:0] req_wdata;
    logic        busy;
    logic        rsp_valid;
    logic        rsp_err;
    logic [15:0] rsp_rdata;
    logic        boot_serial;
    int          n_fail = 0;
    int          tests_run = 0;

    fmbr_top i_dut (.mclk(mclk), .rst(rst), .boot_serial_pin(boot_serial_pin),
        .large_variant_pin(large_variant_pin), .manufacturing_pin(manufacturing_pin),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_size(req_size), .req_addr(req_addr),
        .req_wdata(req_wdata), .busy(busy), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
        .rsp_rdata(rsp_rdata), .boot_serial(boot_serial));
    fmbr_cpu_model i_cpu (.mclk(mclk), .busy(busy), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
        .rsp_rdata(rsp_rdata), .req_valid(req_valid), .req_cmd(req_cmd), .req_size(req_size),
        .req_addr(req_addr), .req_wdata(req_wdata));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic test_done();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic fail(input string msg);
        n_fail++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask : fail

    // Issue one request and compare refusal flag and, for accepted reads, the data
    task automatic req(input logic [1:0] cmd, input logic [1:0] size, input logic [31:0] addr,
                       input logic [15:0] wd, input logic exp_err, input logic [15:0] exp_rd);
        logic        err;
        logic [15:0] rd;
        logic        late;
        i_cpu.access(cmd, size, addr, wd, err, rd, late);
        tests_run++;
        if (late === 1'b1) begin
            fail("request never answered");
            test_done();
        end
        if (err !== exp_err) begin
            fail($sformatf("refusal flag %b at address %h", err, addr));
        end else if (cmd == CMD_READ && exp_err == 1'b0 && rd !== exp_rd) begin
            fail($sformatf("read %h at address %h, expected %h", rd, addr, exp_rd));
        end
    endtask : req

    task automatic boot(input logic serial, input logic large_part);
        int n;
        rst = 1'b1;
        boot_serial_pin = serial;
        large_variant_pin = large_part;
        repeat (8) @(posedge mclk);
        #1;
        rst = 1'b0;
        for (n = 0; n < 16 && busy !== 1'b0; n++) begin
            @(posedge mclk);
            #1;
        end
        tests_run++;
        if (busy !== 1'b0 || boot_serial !== serial) fail("boot mode not captured");
    endtask : boot

    task automatic set_mfg(input logic v);
        manufacturing_pin = v;
        repeat (4) @(posedge mclk);
        #1;
    endtask : set_mfg

    task automatic t_main();
        boot(1'b0, 1'b0);
        req(CMD_ERASE, SIZE_HALF, MAIN_BASE + PAGE_BYTES, 16'h0000, 1'b0, 16'h0000);
        req(CMD_PROG, SIZE_HALF, MAIN_BASE + PAGE_BYTES, 16'h5A5A, 1'b0, 16'h0000);
        req(CMD_ERASE, SIZE_HALF, MAIN_BASE + 32'h10, 16'h0000, 1'b0, 16'h0000);
        req(CMD_READ, SIZE_HALF, MAIN_BASE, 16'h0000, 1'b0, ERASED_HW);
        req(CMD_READ, SIZE_HALF, MAIN_BASE + 32'h7FE, 16'h0000, 1'b0, ERASED_HW);
        req(CMD_READ, SIZE_HALF, MAIN_BASE + PAGE_BYTES, 16'h0000, 1'b0, 16'h5A5A);
        req(CMD_PROG, SIZE_HALF, MAIN_BASE + 32'h2, 16'h1234, 1'b0, 16'h0000);
        req(CMD_READ, SIZE_HALF, ALIAS_BASE + 32'h2, 16'h0000, 1'b0, 16'h1234);
        req(CMD_PROG, SIZE_HALF, ALIAS_BASE + 32'h2, 16'hFF0F, 1'b0, 16'h0000);
        req(CMD_READ, SIZE_HALF, MAIN_BASE + 32'h2, 16'h0000, 1'b0, 16'h1204);
        req(CMD_ERASE, SIZE_HALF, MAIN_BASE + MAIN_BYTES_SM - PAGE_BYTES, 16'h0, 1'b0, 16'h0);
        req(CMD_READ, SIZE_HALF, MAIN_BASE + MAIN_BYTES_SM - 32'h2, 16'h0, 1'b0, ERASED_HW);
        req(CMD_READ, SIZE_HALF, MAIN_BASE + MAIN_BYTES_SM, 16'h0, 1'b1, 16'h0);
        req(CMD_READ, SIZE_HALF, ALIAS_BASE + MAIN_BYTES_SM, 16'h0, 1'b1, 16'h0);
        $display("test main array done");
    endtask : t_main

    task automatic t_refuse();
        req(CMD_PROG, SIZE_BYTE, MAIN_BASE + 32'h4, 16'h0000, 1'b1, 16'h0000);
        req(CMD_PROG, SIZE_WORD, MAIN_BASE + 32'h4, 16'h0000, 1'b1, 16'h0000);
        req(CMD_PROG, SIZE_HALF, MAIN_BASE + 32'h5, 16'h0000, 1'b1, 16'h0000);
        req(2'h3, SIZE_HALF, MAIN_BASE + 32'h4, 16'h0000, 1'b1, 16'h0000);
        req(CMD_READ, SIZE_HALF, MAIN_BASE + 32'h4, 16'h0000, 1'b0, ERASED_HW);
        req(CMD_PROG, SIZE_HALF, FACT_BASE, 16'h0000, 1'b1, 16'h0000);
        req(CMD_ERASE, SIZE_HALF, FACT_BASE, 16'h0000, 1'b1, 16'h0000);
        $display("test refusals done");
    endtask : t_refuse

    task automatic t_info();
        set_mfg(1'b1);
        req(CMD_ERASE, SIZE_HALF, FACT_BASE, 16'h0000, 1'b0, 16'h0000);
        req(CMD_PROG, SIZE_HALF, FACT_BASE, 16'hA5A5, 1'b0, 16'h0000);
        req(CMD_ERASE, SIZE_HALF, USER_BASE, 16'h0000, 1'b0, 16'h0000);
        req(CMD_READ, SIZE_HALF, FACT_BASE, 16'h0000, 1'b0, 16'hA5A5);
        req(CMD_READ, SIZE_HALF, FACT_BASE + 32'h7FE, 16'h0000, 1'b0, ERASED_HW);
        req(CMD_PROG, SIZE_HALF, USER_BASE + 32'h10, 16'h0F0F, 1'b0, 16'h0000);
        req(CMD_READ, SIZE_HALF, USER_BASE + 32'h10, 16'h0000, 1'b0, 16'h0F0F);
        req(CMD_READ, SIZE_HALF, USER_BASE + 32'h7FE, 16'h0000, 1'b0, ERASED_HW);
        req(CMD_READ, SIZE_HALF, USER_BASE + PAGE_BYTES, 16'h0000, 1'b1, 16'h0000);
        set_mfg(1'b0);
        $display("test info pages done");
    endtask : t_info

    task automatic t_serial();
        boot(1'b1, 1'b1);
        boot_serial_pin = 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        tests_run++;
        if (boot_serial !== 1'b1) fail("boot mode changed without reset");
        req(CMD_READ, SIZE_HALF, ALIAS_BASE, 16'h0000, 1'b0, 16'hA5A5);
        req(CMD_READ, SIZE_HALF, ALIAS_BASE + 32'h2, 16'h0000, 1'b0, ERASED_HW);
        req(CMD_READ, SIZE_HALF, ALIAS_BASE + PAGE_BYTES, 16'h0000, 1'b1, 16'h0000);
        req(CMD_READ, SIZE_HALF, MAIN_BASE + 32'h2, 16'h0000, 1'b0, 16'h1204);
        req(CMD_READ, SIZE_HALF, FACT_BASE, 16'h0000, 1'b0, 16'hA5A5);
        req(CMD_ERASE, SIZE_HALF, MAIN_BASE + MAIN_BYTES_LG - PAGE_BYTES, 16'h0, 1'b0, 16'h0);
        req(CMD_READ, SIZE_HALF, MAIN_BASE + MAIN_BYTES_LG - 32'h2, 16'h0, 1'b0, ERASED_HW);
        req(CMD_READ, SIZE_HALF, MAIN_BASE + MAIN_BYTES_LG, 16'h0, 1'b1, 16'h0);
        $display("test serial boot done");
    endtask : t_serial

    initial begin
        t_main();
        t_refuse();
        t_info();
        t_serial();
        test_done();
    end
endmodule : tb_top
